/* rtl/scc_regs.sv */
// sync clock control register slice on the byte-wide register port
// What this block and its host must do
// RULE1 - address steps when freeze is clear
// RULE2 - freeze keeps address constant while streaming
// RULE3 - bit 6 enables sync processor, resets off
// RULE4 - host enables receiver before processor
// RULE5 - bit 5 enables sync receiver, resets off
// RULE6 - bit 4 selects finer window delay steps
// RULE7 - host uses fine scale at high rates
// RULE8 - bits 3:0 choose reference sampling delay
// RULE9 - input mode bit 0 inverts reference
// RULE10 - host writes reserved bits at reset value
// RULE11 - sync control at 0x29, reset 0x80
// RULE12 - input mode at 0x2a, reset 0x00
// RULE13 - noise control at 0x2b, reset 0x10
// RULE14 - direction up increments, resets to up
// RULE15 - read-only 24-bit edge position status
module scc_regs
   import scc_pkg::*;
(
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   input  wire logic                     xfer_start,
   input  wire logic [7:0]               xfer_addr,
   input  wire logic                     byte_valid,
   input  wire logic                     byte_write,
   input  wire logic [7:0]               byte_wdata,
   input  wire logic                     xfer_end,
   input  wire logic [scc_pkg::POS_W-1:0] sync_edge_position,
   input  wire logic                     sync_in,
   output logic      [7:0]               byte_rdata,
   output logic      [7:0]               cur_addr,
   output logic                          sync_processor_enable,
   output logic                          sync_receiver_enable,
   output logic                          sync_window_fine_scale,
   output logic      [3:0]               sync_delay_select,
   output logic                          sample_clock_termination_mode,
   output logic                          sync_input_termination_mode,
   output logic                          sync_aligned,
   output logic      [7:0]               noise_control
);
   import scc_pkg::*;

   typedef struct packed {
      scc_phase_e phase;
      logic [7:0] addr;
      logic [7:0] rdata;
      logic [7:0] stream_ctrl;
      logic [7:0] ascend_ctrl;
      logic [7:0] sync_ctrl;
      logic [7:0] input_mode;
      logic [7:0] noise_ctrl;
      logic       aligned;
   } scc_state_s;

   scc_state_s st;
   scc_state_s next_st;
   logic [7:0] step_addr;
   logic [7:0] rd_mux;

   scc_addr_step u_step (
      .cur_addr             (st.addr),
      .address_freeze       (st.stream_ctrl[BIT_FREEZE]),
      .address_direction_up (st.ascend_ctrl[BIT_ASCEND]),
      .step_addr            (step_addr)
   );

   always_comb
   begin
      // RULE15 position status
      if (st.addr == ADDR_POS_LOW)
         rd_mux = sync_edge_position[7:0];
      else if (st.addr == ADDR_POS_MID)
         rd_mux = sync_edge_position[15:8];
      else if (st.addr == ADDR_POS_HIGH)
         rd_mux = sync_edge_position[23:16];
      else if (st.addr == ADDR_STREAM_CTRL)
         rd_mux = st.stream_ctrl;
      else if (st.addr == ADDR_ASCEND_CTRL)
         rd_mux = st.ascend_ctrl;
      else if (st.addr == ADDR_SYNC_CTRL)
         rd_mux = st.sync_ctrl;
      else if (st.addr == ADDR_INPUT_MODE)
         rd_mux = st.input_mode;
      else if (st.addr == ADDR_NOISE_CTRL)
         rd_mux = st.noise_ctrl;
      else
         rd_mux = 8'h00;
   end

   always_comb
   begin
      next_st = st;
      // RULE9 invert reference
      // RULE5 receiver gates the path; processor alone is not enough
      next_st.aligned = st.sync_ctrl[BIT_PROC_EN] & st.sync_ctrl[BIT_RECV_EN]
                        & (sync_in ^ st.input_mode[BIT_INVERT]);
      case (st.phase)
         SCC_IDLE:
         begin
            if (xfer_start)
            begin
               next_st.addr  = xfer_addr;
               next_st.phase = SCC_FIRST;
            end
         end
         SCC_FIRST, SCC_STREAM:
         begin
            if (xfer_end)
               next_st.phase = SCC_IDLE;
            else if (byte_valid)
            begin
               if (byte_write)
               begin
                  if (st.addr == ADDR_STREAM_CTRL)
                     next_st.stream_ctrl = byte_wdata;
                  else if (st.addr == ADDR_ASCEND_CTRL)
                     // read-only bit always reads one
                     next_st.ascend_ctrl = byte_wdata | ASCEND_RO_MASK;
                  // RULE3 processor enable
                  // RULE6 fine scale
                  // RULE8 delay select
                  else if (st.addr == ADDR_SYNC_CTRL)
                     next_st.sync_ctrl = byte_wdata;
                  else if (st.addr == ADDR_INPUT_MODE)
                     next_st.input_mode = byte_wdata;
                  else if (st.addr == ADDR_NOISE_CTRL)
                     next_st.noise_ctrl = byte_wdata;
               end
               else
                  next_st.rdata = rd_mux;
               next_st.addr  = step_addr;
               next_st.phase = SCC_STREAM;
            end
         end
         default:
            next_st.phase = SCC_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st.phase       <= SCC_IDLE;
         st.addr        <= 8'h00;
         st.rdata       <= 8'h00;
         st.stream_ctrl <= RST_STREAM_CTRL;
         // RULE14 resets ascending
         st.ascend_ctrl <= RST_ASCEND_CTRL;
         // RULE11 sync control reset
         st.sync_ctrl   <= RST_SYNC_CTRL;
         // RULE12 input mode reset
         st.input_mode  <= RST_INPUT_MODE;
         // RULE13 noise reset
         st.noise_ctrl  <= RST_NOISE_CTRL;
         st.aligned     <= 1'b0;
      end
      else
         st <= next_st;
   end

   assign byte_rdata                    = st.rdata;
   assign cur_addr                      = st.addr;
   assign sync_processor_enable         = st.sync_ctrl[BIT_PROC_EN];
   assign sync_receiver_enable          = st.sync_ctrl[BIT_RECV_EN];
   assign sync_window_fine_scale        = st.sync_ctrl[BIT_FINE];
   assign sync_delay_select             = st.sync_ctrl[SEL_HI:SEL_LO];
   assign sample_clock_termination_mode = st.input_mode[BIT_SAMPLE_TERM];
   assign sync_input_termination_mode   = st.input_mode[BIT_SYNC_TERM];
   assign sync_aligned                  = st.aligned;
   assign noise_control                 = st.noise_ctrl;

   a_freeze_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE2
      (st.phase != SCC_IDLE && !xfer_end && byte_valid && st.stream_ctrl[BIT_FREEZE])
      |=> $stable(cur_addr))
      else $error("address moved while frozen");

   a_addr_up: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE14
      (st.phase != SCC_IDLE && !xfer_end && byte_valid && !st.stream_ctrl[BIT_FREEZE]
       && st.ascend_ctrl[BIT_ASCEND]) |=> cur_addr == $past(cur_addr) + ADDR_STEP)
      else $error("address did not increment");

   a_addr_down: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE1
      (st.phase != SCC_IDLE && !xfer_end && byte_valid && !st.stream_ctrl[BIT_FREEZE]
       && !st.ascend_ctrl[BIT_ASCEND]) |=> cur_addr == $past(cur_addr) - ADDR_STEP)
      else $error("address did not decrement");

   a_proc_reset: assert property (@(posedge sys_clk) // RULE3
      $past(sys_rst) |-> !sync_processor_enable && !sync_aligned)
      else $error("processor enabled after reset");

   a_recv_reset: assert property (@(posedge sys_clk) // RULE5
      $past(sys_rst) |-> !sync_receiver_enable)
      else $error("receiver enabled after reset");

   a_ctrl_reset: assert property (@(posedge sys_clk) // RULE11
      $past(sys_rst) |-> st.sync_ctrl == RST_SYNC_CTRL && st.noise_ctrl == RST_NOISE_CTRL)
      else $error("control reset value wrong");

   a_sel_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
      (st.phase != SCC_IDLE && !xfer_end && byte_valid && byte_write
       && cur_addr == ADDR_SYNC_CTRL)
      |=> sync_delay_select == $past(byte_wdata[SEL_HI:SEL_LO])
          && sync_window_fine_scale == $past(byte_wdata[BIT_FINE]))
      else $error("delay select not written");

   a_invert_path: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE9
      (sync_processor_enable && sync_receiver_enable)
      |=> sync_aligned == ($past(sync_in) ^ $past(st.input_mode[BIT_INVERT])))
      else $error("reference polarity wrong");

   a_pos_read: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE15
      (st.phase != SCC_IDLE && !xfer_end && byte_valid && !byte_write
       && cur_addr == ADDR_POS_HIGH) |=> byte_rdata == $past(sync_edge_position[23:16]))
      else $error("position status read wrong");
endmodule

/* common/scc_pkg.sv */
// constants for the sync clock control register slice
package scc_pkg;
   localparam logic [7:0] ADDR_STREAM_CTRL  = 8'h10;
   localparam logic [7:0] ADDR_ASCEND_CTRL  = 8'h00;
   localparam logic [7:0] ADDR_SYNC_CTRL    = 8'h29;
   localparam logic [7:0] ADDR_INPUT_MODE   = 8'h2a;
   localparam logic [7:0] ADDR_NOISE_CTRL   = 8'h2b;
   localparam logic [7:0] ADDR_POS_LOW      = 8'h2c;
   localparam logic [7:0] ADDR_POS_MID      = 8'h2d;
   localparam logic [7:0] ADDR_POS_HIGH     = 8'h2e;
   localparam logic [7:0] RST_STREAM_CTRL   = 8'h00;
   localparam logic [7:0] RST_ASCEND_CTRL   = 8'h30;
   localparam logic [7:0] RST_SYNC_CTRL     = 8'h80;
   localparam logic [7:0] RST_INPUT_MODE    = 8'h00;
   localparam logic [7:0] RST_NOISE_CTRL    = 8'h10;
   localparam logic [7:0] ASCEND_RO_MASK    = 8'h10;
   localparam logic [7:0] ADDR_STEP         = 8'h01;
   localparam int         BIT_FREEZE        = 0;
   localparam int         BIT_ASCEND        = 5;
   localparam int         BIT_PROC_EN       = 6;
   localparam int         BIT_RECV_EN       = 5;
   localparam int         BIT_FINE          = 4;
   localparam int         SEL_HI            = 3;
   localparam int         SEL_LO            = 0;
   localparam int         BIT_INVERT        = 0;
   localparam int         BIT_SAMPLE_TERM   = 2;
   localparam int         BIT_SYNC_TERM     = 1;
   localparam int         POS_W             = 24;
   typedef enum logic [1:0] {SCC_IDLE, SCC_FIRST, SCC_STREAM} scc_phase_e;
endpackage

/* rtl/scc_addr_step.sv */
// next streaming address from hold and direction settings
module scc_addr_step
   import scc_pkg::*;
(
   input  wire logic [7:0] cur_addr,
   input  wire logic       address_freeze,
   input  wire logic       address_direction_up,
   output logic      [7:0] step_addr
);
   always_comb
   begin
      // RULE2 hold address
      if (address_freeze)
         step_addr = cur_addr;
      // RULE1 step address
      // RULE14 up or down
      else if (address_direction_up)
         step_addr = cur_addr + ADDR_STEP;
      else
         step_addr = cur_addr - ADDR_STEP;
   end
endmodule

/* sim/scc_host.sv */
// host model driving the byte-framed register port
module scc_host
(
   input  wire logic       sys_clk,
   output logic            xfer_start,
   output logic      [7:0] xfer_addr,
   output logic            byte_valid,
   output logic            byte_write,
   output logic      [7:0] byte_wdata,
   output logic            xfer_end,
   input  wire logic [7:0] byte_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {xfer_start, byte_valid, byte_write, xfer_end} = 4'h0;
      xfer_addr = 8'h00;
      byte_wdata = 8'h00;
   end
   // top bit kept, receiver with processor
   function automatic logic [7:0] legal_ctrl(input logic [7:0] v);
      return v | 8'h80 | (v[6] ? 8'h20 : 8'h00);
   endfunction
   // one frame: n bytes at a, then end pulse
   task automatic xfer(input logic [7:0] a, input int n, input logic wr,
                       input logic [7:0] wd [5], output logic [7:0] rd [5]);
      @(negedge sys_clk);
      xfer_start = 1'b1;
      xfer_addr = a;
      for (int i = 0; i <= n; i++)
      begin
         @(negedge sys_clk);
         xfer_start = 1'b0;
         xfer_addr = ~a;
         if (i > 0 && !wr)
            rd[i-1] = byte_rdata;
         byte_valid = (i < n);
         byte_write = wr;
         byte_wdata = (i == n) ? ~byte_wdata : (a == 8'h29) ? legal_ctrl(wd[i]) : wd[i];
         xfer_end = (i == n);
      end
      @(negedge sys_clk);
      xfer_end = 1'b0;
   endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the sync clock control register slice
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import scc_pkg::*;
   logic sys_clk, sys_rst, xfer_start, byte_valid, byte_write, xfer_end, sync_in;
   logic [7:0] xfer_addr, byte_wdata, byte_rdata, cur_addr, noise_control;
   logic [23:0] sync_edge_position;
   logic proc_en, recv_en, fine, samp_term, sync_term, sync_aligned;
   logic [3:0] sel;
   logic [7:0] shadow [256];
   logic [7:0] wd [5];
   logic [7:0] rd [5];
   logic [31:0] lfsr_q;
   int errors, total_checks, cycles;

   scc_host i_scc_host (.sys_clk(sys_clk), .xfer_start(xfer_start), .xfer_addr(xfer_addr),
      .byte_valid(byte_valid), .byte_write(byte_write), .byte_wdata(byte_wdata),
      .xfer_end(xfer_end), .byte_rdata(byte_rdata));
   scc_regs i_scc_regs (.sys_clk(sys_clk), .sys_rst(sys_rst), .xfer_start(xfer_start),
      .xfer_addr(xfer_addr), .byte_valid(byte_valid), .byte_write(byte_write),
      .byte_wdata(byte_wdata), .xfer_end(xfer_end), .sync_edge_position(sync_edge_position),
      .sync_in(sync_in), .byte_rdata(byte_rdata), .cur_addr(cur_addr),
      .sync_processor_enable(proc_en), .sync_receiver_enable(recv_en),
      .sync_window_fine_scale(fine), .sync_delay_select(sel),
      .sample_clock_termination_mode(samp_term), .sync_input_termination_mode(sync_term),
      .sync_aligned(sync_aligned), .noise_control(noise_control));

   initial sys_clk = 1'b0;
   always #25 sys_clk = ~sys_clk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      return (a == 8'h2c) ? sync_edge_position[7:0] : (a == 8'h2d) ? sync_edge_position[15:8]
         : (a == 8'h2e) ? sync_edge_position[23:16] : shadow[a];
   endfunction
   // hold wins, else direction bit picks up or down
   function automatic logic [7:0] next_a(input logic [7:0] a);
      return shadow[8'h10][0] ? a : shadow[8'h00][5] ? a + 8'h01 : a - 8'h01;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rw(input logic [7:0] a, input int n, input logic wr);
      logic [7:0] ad;
      ad = a;
      i_scc_host.xfer(a, n, wr, wd, rd);
      for (int i = 0; i < n; i++)
      begin
         if (!wr)
            chk(rd[i], exp_rd(ad));
         else if (ad == 8'h29)
            shadow[ad] = i_scc_host.legal_ctrl(wd[i]);
         else if (ad == 8'h00 || ad == 8'h10 || ad == 8'h2a || ad == 8'h2b)
            shadow[ad] = (ad == 8'h00) ? (wd[i] | 8'h10) : wd[i];
         ad = next_a(ad);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         wrap_up();
      end
   end

   initial
   begin
      sys_rst = 1'b1;
      sync_in = 1'b0;
      sync_edge_position = 24'h000000;
      lfsr_q = 32'h72e09a18;
      foreach (shadow[i]) shadow[i] = 8'h00;
      shadow[8'h00] = 8'h30;
      shadow[8'h29] = 8'h80;
      shadow[8'h2b] = 8'h10;
      repeat (3) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk({proc_en, recv_en, 6'h00}, 8'h00);
      rw(8'h29, 3, 1'b0);
      rw(8'h00, 1, 1'b0);
      rw(8'h10, 1, 1'b0);
      $display("reset values done");
      for (int k = 0; k < 6; k++)
      begin
         lfsr_q = lfsr(lfsr_q);
         wd[0] = i_scc_host.legal_ctrl(lfsr_q[7:0]) & 8'hbf;
         rw(8'h29, 1, 1'b1);
         wd[0] = lfsr_q[7:0];
         rw(8'h29, 1, 1'b1);
         chk({1'b1, proc_en, recv_en, fine, sel}, shadow[8'h29]);
         wd[0] = {5'h00, lfsr_q[10:8]};
         // reserved bits of noise control kept at their reset value
         wd[1] = {5'h02, lfsr_q[26], 1'b0, lfsr_q[24]};
         rw(8'h2a, 2, 1'b1);
         chk(noise_control, shadow[8'h2b]);
         sync_in = lfsr_q[16];
         @(negedge sys_clk);
         chk({samp_term, sync_term, sync_aligned}, {shadow[8'h2a][2:1],
             (lfsr_q[16] ^ shadow[8'h2a][0]) & shadow[8'h29][6] & shadow[8'h29][5]});
         sync_edge_position = lfsr_q[31:8];
         rw(8'h29, 4, 1'b0);
      end
      $display("random control done");
      wd[0] = 8'h37;
      rw(8'h29, 1, 1'b1);
      chk({7'h00, fine}, 8'h01);
      wd[0] = 8'h01;
      rw(8'h10, 1, 1'b1);
      // reserved bits stay at reset value
      wd = '{8'h14, 8'h11, 8'h15, 8'h00, 8'h00};
      rw(8'h2b, 3, 1'b1);
      chk(noise_control, 8'h15);
      chk(cur_addr, 8'h2b);
      rw(8'h2d, 2, 1'b0);
      wd[0] = 8'h00;
      rw(8'h10, 1, 1'b1);
      rw(8'h00, 1, 1'b1);
      rw(8'h2e, 4, 1'b0);
      wd[0] = 8'h20;
      rw(8'h00, 1, 1'b1);
      wd[0] = 8'ha5;
      rw(8'h50, 1, 1'b1);
      rw(8'h2c, 1, 1'b1);
      rw(8'h50, 1, 1'b0);
      rw(8'h2c, 1, 1'b0);
      $display("stepping and refusal done");
      wrap_up();
   end
endmodule
